//--- rtl/diag_seq_pkg.sv
// Constants, encodings and fault resolver of the diagnostic sequencer.
// Assumes a 10 MHz system clock and decoded instruction bytes.
package diag_seq_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLOCK_PERIOD_NS = 100;
    localparam int unsigned NS_PER_MS       = 1000000;
    localparam int unsigned CYCLES_PER_MS   = NS_PER_MS / CLOCK_PERIOD_NS;
    localparam int unsigned TB_WIDTH        = 24;
    localparam logic [6:0]  CHECK_TIME_MS   = 7'h01;  // Overload recheck delay.
    localparam logic [6:0]  DIAG_TIME_MS    = 7'h64;  // Permanent diagnostic cycle, 100 ms.
    localparam logic [6:0]  ACQ_TIME_MS     = 7'h64;  // Turn-on acquisition, 100 ms.
    localparam logic [1:0]  TWEETER_PEAKS   = 2'h3;   // Peaks needed to confirm a tweeter.

    // ------------------------------------------------------------------
    // Instruction byte fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned IB1_DIAG_EN     = 6;
    localparam int unsigned IB1_OFFSET_EN   = 5;
    localparam int unsigned IB1_FRONT_16DB  = 4;
    localparam int unsigned IB1_REAR_16DB   = 3;
    localparam int unsigned IB2_STANDBY_OFF = 4;
    localparam int unsigned IB2_LINE_DRIVER = 3;
    localparam int unsigned IB2_CURRENT_EN  = 2;
    localparam logic [7:0]  IB1_RESET       = 8'h00;
    localparam logic [7:0]  IB2_RESET       = 8'h00;

    // ------------------------------------------------------------------
    // Channels: 0 = LF, 1 = RF, 2 = LR, 3 = RR
    // ------------------------------------------------------------------
    localparam int unsigned NUM_CH          = 4;
    localparam logic [3:0]  SOURCE_ON_NEG   = 4'h6;   // RF and LR source on the minus output.

    typedef enum logic [1:0] {
        TOP_STANDBY = 2'b00,
        TOP_PULSE   = 2'b01,
        TOP_BIASED  = 2'b10
    } top_state_e;

    typedef enum logic [1:0] {
        CH_ACTIVE  = 2'b00,
        CH_CHECK   = 2'b01,
        CH_DIAG    = 2'b10,
        CH_RESTART = 2'b11
    } ch_state_e;

    // Double fault resolution; returns {ground, supply, shorted load, open load}.
    function automatic logic [3:0] resolve(input logic gnd_src, input logic gnd_snk,
                                           input logic vs, input logic sl, input logic ol);
        logic [3:0] r;
        r = 4'h0;
        if (vs)           r = {gnd_src, 1'b1, 1'b0, 1'b0};
        else if (gnd_src) r = 4'h8;
        else if (gnd_snk) r = ol ? 4'h1 : 4'h8;
        else if (sl)      r = 4'h2;
        else if (ol)      r = 4'h1;
        return r;
    endfunction : resolve

endpackage : diag_seq_pkg

//--- rtl/load_diagnostic_sequencer.sv
// Four channel diagnostic sequencer: turn-on test, short monitoring,
// offset and tweeter detection, with read-armed result capture.
// Assumes bytes and read completions arrive on i_link_clock,
// and that comparator inputs are asynchronous levels.
`timescale 1ns/1ps

// Overview of operation
// - Turn-on test only on standby exit with diagnostics on.
// - Turn-on result held until a new pulse after a read.
// - Exit and enable together: pulse first, stage in standby.
// - Once biased, monitor; keep turn-on result until a short.
// - Status latched at end of the 100 ms pulse top.
// - Line-driver load thresholds at 16 dB plus line option.
// - Diagnostics off: faulted channel alone off, rechecked each 1 ms.
// - Diagnostics on: recheck after 1 ms; no overload, back to active.
// - Overload at recheck starts a 100 ms diagnostic cycle.
// - After the cycle: restart mode, fault data stored.
// - Next cycle armed only by a host read.
// - Offset beyond 2 V is reported.
// - Offset window from read or offset enable to next read.
// - Offset flagged only if held all window.
// - Overload protection voids offset and current tests.
// - Tweeter present only with three 500 mA peaks.
// - Of several faults one is kept, or supply plus source-side ground; later reads repeat it, except a permanent one that a read clears with the channel active.
// - Supply short dominates, with pair exceptions by side.
// - Monitoring never reports an open load.
// - A read re-arms cycles, returns previous cycle data.
// - First instruction byte bit 6 enables diagnostics.
// - Second instruction byte bit 3 selects line-driver thresholds.
module load_diagnostic_sequencer #(
    parameter int unsigned P_CYCLES_PER_MS = diag_seq_pkg::CYCLES_PER_MS
) (
    input  wire logic       i_clock,
    input  wire logic       i_sys_rst,
    input  wire logic       i_link_clock,
    input  wire logic       i_link_write,
    input  wire logic [7:0] i_link_first_instruction_byte,
    input  wire logic [7:0] i_link_second_instruction_byte,
    input  wire logic       i_link_read_done,
    input  wire logic [3:0] i_overload,
    input  wire logic [3:0] i_short_gnd_pos,
    input  wire logic [3:0] i_short_gnd_neg,
    input  wire logic [3:0] i_short_vs,
    input  wire logic [3:0] i_short_load,
    input  wire logic [3:0] i_open_load,
    input  wire logic [3:0] i_offset_high,
    input  wire logic [3:0] i_current_peak,
    output logic            o_standby,
    output logic            o_test_pulse,
    output logic [3:0]      o_line_thresholds,
    output logic [3:0]      o_channel_off,
    output logic [3:0]      o_restart_mode,
    output logic [3:0]      o_rep_short_gnd,
    output logic [3:0]      o_rep_short_vs,
    output logic [3:0]      o_rep_short_load,
    output logic [3:0]      o_rep_open_load,
    output logic [3:0]      o_rep_permanent,
    output logic [3:0]      o_rep_offset,
    output logic [3:0]      o_rep_tweeter_open,
    output logic [3:0]      o_rep_cycle_done
);

    // ------------------------------------------------------------------
    // Link domain: instruction capture and read events
    // ------------------------------------------------------------------
    logic [1:0] link_rst_sync_q;
    logic       wr_tog_q;
    logic       rd_tog_q;
    logic [7:0] ib1_hold_q;
    logic [7:0] ib2_hold_q;

    // System reset is brought into the link domain as a level.
    always_ff @(posedge i_link_clock) begin
        link_rst_sync_q <= {link_rst_sync_q[0], i_sys_rst};
    end

    // Bytes are held stable while the write toggle crosses over.
    always_ff @(posedge i_link_clock) begin
        if (link_rst_sync_q[1]) begin
            wr_tog_q   <= 1'b0;
            ib1_hold_q <= diag_seq_pkg::IB1_RESET;
            ib2_hold_q <= diag_seq_pkg::IB2_RESET;
        end else if (i_link_write) begin
            wr_tog_q   <= ~wr_tog_q;
            ib1_hold_q <= i_link_first_instruction_byte;
            ib2_hold_q <= i_link_second_instruction_byte;
        end
    end

    // Each completed host read flips this toggle.
    always_ff @(posedge i_link_clock) begin
        if (link_rst_sync_q[1]) begin
            rd_tog_q <= 1'b0;
        end else if (i_link_read_done) begin
            rd_tog_q <= ~rd_tog_q;
        end
    end

    // ------------------------------------------------------------------
    // Crossings into the system domain
    // ------------------------------------------------------------------
    logic [2:0]  wr_sync_q;
    logic [2:0]  rd_sync_q;
    logic        wr_evt;
    logic        read_evt;
    logic [31:0] cmp_sync0_q;
    logic [31:0] cmp_sync1_q;
    logic [3:0]  peak_prev_q;

    // Toggles pass two flops; the third stage only serves the edge compare.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            wr_sync_q <= 3'h0;
            rd_sync_q <= 3'h0;
        end else begin
            wr_sync_q <= {wr_sync_q[1:0], wr_tog_q};
            rd_sync_q <= {rd_sync_q[1:0], rd_tog_q};
        end
    end

    assign wr_evt   = wr_sync_q[2] ^ wr_sync_q[1];
    assign read_evt = rd_sync_q[2] ^ rd_sync_q[1];

    // Comparator levels are asynchronous: two flops each.
    always_ff @(posedge i_clock) begin
        cmp_sync0_q <= {i_overload, i_short_gnd_pos, i_short_gnd_neg, i_short_vs,
                        i_short_load, i_open_load, i_offset_high, i_current_peak};
        cmp_sync1_q <= cmp_sync0_q;
        peak_prev_q <= cmp_sync1_q[3:0];
    end

    // ------------------------------------------------------------------
    // Instruction bytes in the system domain
    // ------------------------------------------------------------------
    logic [7:0] ib1_q;
    logic [7:0] ib2_q;
    logic       offset_en_prev_q;
    logic       current_en_prev_q;
    logic       diag_en;
    logic       offset_start;
    logic       current_start;

    // The hold registers are quiet by the time the toggle edge is seen.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            ib1_q             <= diag_seq_pkg::IB1_RESET;
            ib2_q             <= diag_seq_pkg::IB2_RESET;
            offset_en_prev_q  <= 1'b0;
            current_en_prev_q <= 1'b0;
        end else begin
            if (wr_evt) begin
                ib1_q <= ib1_hold_q;
                ib2_q <= ib2_hold_q;
            end
            offset_en_prev_q  <= ib1_q[diag_seq_pkg::IB1_OFFSET_EN];
            current_en_prev_q <= ib2_q[diag_seq_pkg::IB2_CURRENT_EN];
        end
    end

    assign diag_en       = ib1_q[diag_seq_pkg::IB1_DIAG_EN];
    assign offset_start  = read_evt | (ib1_q[diag_seq_pkg::IB1_OFFSET_EN]
                                       & ~offset_en_prev_q);
    assign current_start = read_evt | (ib2_q[diag_seq_pkg::IB2_CURRENT_EN]
                                       & ~current_en_prev_q);

    // Line-driver thresholds need both the 16 dB gain and the line option.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_line_thresholds <= 4'h0;
        end else begin
            o_line_thresholds <= {4{ib2_q[diag_seq_pkg::IB2_LINE_DRIVER]}}
                                 & {{2{ib1_q[diag_seq_pkg::IB1_REAR_16DB]}},
                                    {2{ib1_q[diag_seq_pkg::IB1_FRONT_16DB]}}};
        end
    end

    // ------------------------------------------------------------------
    // Timebase
    // ------------------------------------------------------------------
    logic [diag_seq_pkg::TB_WIDTH-1:0] tb_q;
    logic                              ms_tick_q;

    // One counter paces every check and cycle, trading exactness for area.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            tb_q      <= '0;
            ms_tick_q <= 1'b0;
        end else if (tb_q == diag_seq_pkg::TB_WIDTH'(P_CYCLES_PER_MS - 1)) begin
            tb_q      <= '0;
            ms_tick_q <= 1'b1;
        end else begin
            tb_q      <= tb_q + 1'b1;
            ms_tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Turn-on sequencing
    // ------------------------------------------------------------------
    diag_seq_pkg::top_state_e top_q;
    logic [6:0]               top_ms_q;
    logic                     pulse_end;
    logic                     biased;
    logic                     standby_off;

    assign standby_off = ib2_q[diag_seq_pkg::IB2_STANDBY_OFF];
    assign biased      = (top_q == diag_seq_pkg::TOP_BIASED);
    assign pulse_end   = (top_q == diag_seq_pkg::TOP_PULSE) && ms_tick_q
                         && (top_ms_q == diag_seq_pkg::ACQ_TIME_MS);

    // The test pulse runs with the stage still in standby; biasing follows.
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            top_q        <= diag_seq_pkg::TOP_STANDBY;
            top_ms_q     <= 7'h00;
            o_standby    <= 1'b1;
            o_test_pulse <= 1'b0;
        end else begin
            unique case (top_q)
                diag_seq_pkg::TOP_STANDBY: begin
                    top_ms_q <= 7'h00;
                    if (standby_off && diag_en) begin
                        top_q        <= diag_seq_pkg::TOP_PULSE;
                        o_test_pulse <= 1'b1;
                    end else if (standby_off) begin
                        top_q     <= diag_seq_pkg::TOP_BIASED;
                        o_standby <= 1'b0;
                    end
                end
                diag_seq_pkg::TOP_PULSE: begin
                    if (!standby_off) begin
                        top_q        <= diag_seq_pkg::TOP_STANDBY;
                        o_test_pulse <= 1'b0;
                    end else if (pulse_end) begin
                        top_q        <= diag_seq_pkg::TOP_BIASED;
                        o_test_pulse <= 1'b0;
                        o_standby    <= 1'b0;
                    end else if (ms_tick_q) begin
                        top_ms_q <= top_ms_q + 1'b1;
                    end
                end
                diag_seq_pkg::TOP_BIASED: begin
                    if (!standby_off) begin
                        top_q     <= diag_seq_pkg::TOP_STANDBY;
                        o_standby <= 1'b1;
                    end
                end
                default: begin
                    top_q        <= diag_seq_pkg::TOP_STANDBY;
                    o_standby    <= 1'b1;
                    o_test_pulse <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Per channel monitoring, offset and current detection
    // ------------------------------------------------------------------
    for (genvar c = 0; c < diag_seq_pkg::NUM_CH; c++) begin : g_ch
        diag_seq_pkg::ch_state_e st_q;
        logic [6:0] ms_q;
        logic       off_q;
        logic       restart_q;
        logic       armed_q;
        logic [3:0] fault_q;
        logic       perm_q;
        logic       done_q;
        logic       ofs_ok_q;
        logic       sup_q;
        logic [1:0] peaks_q;
        logic [3:0] rep_fault_q;
        logic       rep_perm_q;
        logic       rep_ofs_q;
        logic       rep_tw_q;
        logic       rep_done_q;
        logic       ovl;
        logic       gnd_src;
        logic       gnd_snk;
        logic       diag_fin;
        logic [3:0] res_ton;
        logic [3:0] res_perm;

        assign ovl      = cmp_sync1_q[28 + c];
        assign gnd_src  = diag_seq_pkg::SOURCE_ON_NEG[c] ? cmp_sync1_q[20 + c]
                                                         : cmp_sync1_q[24 + c];
        assign gnd_snk  = diag_seq_pkg::SOURCE_ON_NEG[c] ? cmp_sync1_q[24 + c]
                                                         : cmp_sync1_q[20 + c];
        assign res_ton  = diag_seq_pkg::resolve(gnd_src, gnd_snk, cmp_sync1_q[16 + c],
                                                cmp_sync1_q[12 + c], cmp_sync1_q[8 + c]);
        assign res_perm = diag_seq_pkg::resolve(gnd_src, gnd_snk, cmp_sync1_q[16 + c],
                                                cmp_sync1_q[12 + c], 1'b0);
        assign diag_fin = (st_q == diag_seq_pkg::CH_DIAG) && ms_tick_q
                          && (ms_q == diag_seq_pkg::DIAG_TIME_MS);

        // Shutdown, recheck and restart of this channel only.
        always_ff @(posedge i_clock) begin
            if (i_sys_rst || !biased || !standby_off) begin
                st_q      <= diag_seq_pkg::CH_ACTIVE;
                ms_q      <= 7'h00;
                off_q     <= 1'b0;
                restart_q <= 1'b0;
            end else begin
                if (ms_tick_q) begin
                    ms_q <= ms_q + 1'b1;
                end
                unique case (st_q)
                    diag_seq_pkg::CH_ACTIVE: begin
                        if (ovl) begin
                            off_q <= 1'b1;
                            ms_q  <= 7'h00;
                            st_q  <= diag_en ? diag_seq_pkg::CH_CHECK
                                             : diag_seq_pkg::CH_RESTART;
                            restart_q <= !diag_en;
                        end
                    end
                    diag_seq_pkg::CH_CHECK: begin
                        if (ms_tick_q && ms_q == diag_seq_pkg::CHECK_TIME_MS) begin
                            ms_q <= 7'h00;
                            if (!ovl) begin
                                st_q  <= diag_seq_pkg::CH_ACTIVE;
                                off_q <= 1'b0;
                            end else if (armed_q) begin
                                st_q <= diag_seq_pkg::CH_DIAG;
                            end else begin
                                st_q      <= diag_seq_pkg::CH_RESTART;
                                restart_q <= 1'b1;
                            end
                        end
                    end
                    diag_seq_pkg::CH_DIAG: begin
                        if (diag_fin) begin
                            st_q      <= diag_seq_pkg::CH_RESTART;
                            restart_q <= 1'b1;
                        end
                    end
                    diag_seq_pkg::CH_RESTART: begin
                        if (ms_tick_q && !ovl) begin
                            st_q      <= diag_seq_pkg::CH_ACTIVE;
                            off_q     <= 1'b0;
                            restart_q <= 1'b0;
                        end
                    end
                endcase
            end
        end

        // Fault record; a set in the read cycle wins.
        always_ff @(posedge i_clock) begin
            if (i_sys_rst) begin
                fault_q <= 4'h0;
                perm_q  <= 1'b0;
                done_q  <= 1'b0;
                armed_q <= 1'b1;
            end else begin
                if (read_evt) begin
                    armed_q <= 1'b1;
                    done_q  <= 1'b0;
                    if (perm_q && st_q == diag_seq_pkg::CH_ACTIVE) begin
                        fault_q <= 4'h0;
                        perm_q  <= 1'b0;
                    end
                end
                if (pulse_end) begin
                    fault_q <= res_ton;
                    perm_q  <= 1'b0;
                    done_q  <= 1'b1;
                end
                if (diag_fin) begin
                    fault_q <= res_perm;
                    perm_q  <= 1'b1;
                    done_q  <= 1'b1;
                    armed_q <= 1'b0;
                end
            end
        end

        // Offset must hold all window; overload voids both.
        always_ff @(posedge i_clock) begin
            if (i_sys_rst) begin
                ofs_ok_q <= 1'b0;
                sup_q    <= 1'b0;
                peaks_q  <= 2'h0;
            end else begin
                if (offset_start) begin
                    ofs_ok_q <= 1'b1;
                end else if (!cmp_sync1_q[4 + c]) begin
                    ofs_ok_q <= 1'b0;
                end
                if (offset_start || current_start) begin
                    sup_q <= 1'b0;
                end else if (ovl) begin
                    sup_q <= 1'b1;
                end
                if (current_start) begin
                    peaks_q <= 2'h0;
                end else if (cmp_sync1_q[c] && !peak_prev_q[c]
                             && peaks_q != diag_seq_pkg::TWEETER_PEAKS) begin
                    peaks_q <= peaks_q + 1'b1;
                end
            end
        end

        // Each read publishes the cycle that just closed.
        always_ff @(posedge i_clock) begin
            if (i_sys_rst) begin
                rep_fault_q <= 4'h0;
                rep_perm_q  <= 1'b0;
                rep_ofs_q   <= 1'b0;
                rep_tw_q    <= 1'b0;
                rep_done_q  <= 1'b0;
            end else if (read_evt) begin
                rep_fault_q <= fault_q;
                rep_perm_q  <= perm_q;
                rep_done_q  <= done_q;
                rep_ofs_q   <= ib1_q[diag_seq_pkg::IB1_OFFSET_EN] & ofs_ok_q & ~sup_q;
                rep_tw_q    <= ib2_q[diag_seq_pkg::IB2_CURRENT_EN] & ~sup_q
                               & (peaks_q != diag_seq_pkg::TWEETER_PEAKS);
            end
        end

        assign o_channel_off[c]      = off_q;
        assign o_restart_mode[c]     = restart_q;
        assign o_rep_short_gnd[c]    = rep_fault_q[3];
        assign o_rep_short_vs[c]     = rep_fault_q[2];
        assign o_rep_short_load[c]   = rep_fault_q[1];
        assign o_rep_open_load[c]    = rep_fault_q[0];
        assign o_rep_permanent[c]    = rep_perm_q;
        assign o_rep_offset[c]       = rep_ofs_q;
        assign o_rep_tweeter_open[c] = rep_tw_q;
        assign o_rep_cycle_done[c]   = rep_done_q;
    end

endmodule : load_diagnostic_sequencer

//--- dv/diag_chk.sv
// Port checker of the sequencer.
// Assumes binding into each instance.
`timescale 1ns/1ps
module diag_chk #(
    parameter int unsigned P_CYCLES_PER_MS = 10000
) (
    input wire logic       i_clock,
    input wire logic       i_sys_rst,
    input wire logic       i_link_read_done,
    input wire logic [3:0] i_overload,
    input wire logic       o_standby,
    input wire logic       o_test_pulse,
    input wire logic [3:0] o_channel_off,
    input wire logic [3:0] o_rep_short_gnd,
    input wire logic [3:0] o_rep_short_vs,
    input wire logic [3:0] o_rep_short_load,
    input wire logic [3:0] o_rep_open_load,
    input wire logic [3:0] o_rep_permanent
);
    localparam int PMIN = 100 * P_CYCLES_PER_MS - 2;
    localparam int PMAX = 102 * P_CYCLES_PER_MS;
    logic [6:0]  rd_q;
    logic [31:0] pc_q;
    // Read window and pulse length.
    always_ff @(posedge i_clock) begin
        rd_q <= i_sys_rst ? 7'h00 : {rd_q[5:0], i_link_read_done};
        pc_q <= (i_sys_rst || !o_test_pulse) ? 32'h0 : pc_q + 32'h1;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    a_pulse_in_standby: assert property (o_test_pulse |-> o_standby)
        else $error("test pulse outside standby");
    a_pulse_length: assert property ($fell(o_test_pulse) |-> pc_q >= PMIN && pc_q <= PMAX)
        else $error("test pulse length wrong");
    a_bias_after_pulse: assert property ($fell(o_test_pulse) |-> !o_standby)
        else $error("stage not biased after pulse");
    a_change_on_read: assert property (!$stable({o_rep_short_gnd, o_rep_short_vs,
        o_rep_short_load, o_rep_open_load, o_rep_permanent}) |-> rd_q != 7'h00)
        else $error("report changed without read");
    a_supply_dominates: assert property (((o_rep_short_vs | o_rep_short_gnd) &
        (o_rep_short_load | o_rep_open_load)) == 4'h0) else $error("bad fault pair");
    a_no_perm_open: assert property ((o_rep_permanent & o_rep_open_load) == 4'h0)
        else $error("open load from monitoring");
    a_off_from_load: assert property (((o_channel_off & ~$past(o_channel_off)) &
        ~($past(i_overload) | $past(i_overload, 2) | $past(i_overload, 3))) == 4'h0)
        else $error("channel off without overload");
    a_off_when_biased: assert property ((o_channel_off != 4'h0) |-> !o_standby)
        else $error("channel off in standby");
endmodule : diag_chk
bind load_diagnostic_sequencer diag_chk #(.P_CYCLES_PER_MS(P_CYCLES_PER_MS)) i_diag_chk (.*);

//--- dv/host_model.sv
// Host side of the link: writes and reads.
// Assumes a free-running link clock.
`timescale 1ns/1ps
module host_model (
    input  wire logic  i_link_clock,
    output logic       o_write,
    output logic [7:0] o_ib1,
    output logic [7:0] o_ib2,
    output logic       o_read_done
);
    // Idle bytes show the inverse of the last write.
    initial begin
        {o_write, o_read_done} = 2'b00;
        {o_ib1, o_ib2} = 16'hFFFF;
    end
    task automatic wr(input logic [7:0] b1, input logic [7:0] b2);
        @(negedge i_link_clock);
        {o_write, o_ib1, o_ib2} = {1'b1, b1, b2};
        @(negedge i_link_clock);
        {o_write, o_ib1, o_ib2} = {1'b0, ~b1, ~b2};
    endtask : wr
    // One link cycle marks a read.
    task automatic rd();
        @(negedge i_link_clock);
        o_read_done = 1'b1;
        @(negedge i_link_clock);
        o_read_done = 1'b0;
    endtask : rd
endmodule : host_model

//--- dv/tb_top.sv
// Bench: turn-on, permanent cycle, glitch, offset and tweeter.
// Assumes the host model owns the link pins.
`timescale 1ns/1ps
module tb_top;
    logic i_clock = 1'b0, i_sys_rst = 1'b1, i_link_clock = 1'b0, i_link_write, i_link_read_done;
    logic o_standby, o_test_pulse;
    logic [7:0] i_link_first_instruction_byte, i_link_second_instruction_byte;
    logic [3:0] i_overload, i_short_gnd_pos, i_short_gnd_neg, i_short_vs, i_short_load;
    logic [3:0] i_open_load, i_offset_high, i_current_peak, o_line_thresholds, o_channel_off;
    logic [3:0] o_restart_mode, o_rep_short_gnd, o_rep_short_vs, o_rep_short_load;
    logic [3:0] o_rep_open_load, o_rep_permanent, o_rep_offset, o_rep_tweeter_open;
    logic [3:0] o_rep_cycle_done;
    int error_cnt = 0;
    int num_checks = 0;
    load_diagnostic_sequencer #(.P_CYCLES_PER_MS(10)) i_load_diagnostic_sequencer (.*);
    host_model i_host_model (.i_link_clock, .o_write(i_link_write),
        .o_ib1(i_link_first_instruction_byte), .o_ib2(i_link_second_instruction_byte),
        .o_read_done(i_link_read_done));
    // Link clock runs off phase.
    initial forever #50 i_clock = ~i_clock;
    initial #17 forever #62.5 i_link_clock = ~i_link_clock;
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clock);
    endtask : cyc
    task automatic chk(input string n, input logic [3:0] e, input logic [3:0] s);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // Spacing keeps requests apart.
    task automatic w(input logic [7:0] b1, input logic [7:0] b2);
        i_host_model.wr(b1, b2);
        cyc(100);
    endtask : w
    task automatic r();
        i_host_model.rd();
        cyc(20);
    endtask : r
    task automatic s_turn_on();
        int i;
        {i_short_gnd_neg, i_short_vs, i_short_load, i_open_load} = 16'h3241;
        w(8'h40, 8'h18);
        chk("pulse_stby", 4'h3, {2'h0, o_test_pulse, o_standby});
        chk("thr", 4'h0, o_line_thresholds);
        for (i = 0; i < 1200 && o_test_pulse !== 1'b0; i++) cyc(1);
        if (i == 1200) begin
            error_cnt++;
            wrap_up();
        end
        chk("stby", 4'h0, {3'h0, o_standby});
        chk("early", 4'h0, o_rep_short_vs);
        {i_short_gnd_neg, i_short_vs, i_short_load, i_open_load} = 16'h0000;
        r();
        chk("gnd", 4'h2, o_rep_short_gnd);
        chk("vs", 4'h2, o_rep_short_vs);
        chk("sl", 4'h4, o_rep_short_load);
        chk("ol", 4'h1, o_rep_open_load);
        w(8'h50, 8'h18);
        chk("thr16", 4'h3, o_line_thresholds);
    endtask : s_turn_on
    task automatic s_perm();
        {i_overload, i_short_gnd_pos, i_open_load} = 12'h888;
        cyc(5);
        chk("off", 4'h8, o_channel_off);
        cyc(1100);
        chk("restart", 4'h8, o_restart_mode);
        {i_overload, i_short_gnd_pos, i_open_load} = 12'h000;
        r();
        chk("pgnd", 4'h8, o_rep_short_gnd & 4'h8);
        chk("perm", 4'h8, o_rep_permanent & o_rep_cycle_done & 4'h8);
        chk("pol", 4'h0, o_rep_open_load & 4'h8);
    endtask : s_perm
    task automatic s_glitch();
        i_overload = 4'h4;
        cyc(4);
        chk("off2", 4'h4, o_channel_off & 4'h4);
        i_overload = 4'h0;
        cyc(40);
        chk("back", 4'h0, o_channel_off | o_restart_mode);
    endtask : s_glitch
    task automatic s_windows();
        int k;
        i_offset_high = 4'h1;
        w(8'h70, 8'h1C);
        r();
        for (k = 0; k < 3; k++) begin
            i_current_peak = (k < 2) ? 4'h6 : 4'h2;
            cyc(3);
            i_current_peak = 4'h0;
            cyc(3);
        end
        r();
        chk("ofs", 4'h1, o_rep_offset);
        chk("tweeter", 4'hD, o_rep_tweeter_open);
        i_offset_high = 4'h3;
        i_overload = 4'h1;
        cyc(4);
        i_overload = 4'h0;
        r();
        chk("ofs_sup", 4'h0, o_rep_offset);
    endtask : s_windows
    initial begin
        {i_overload, i_short_gnd_pos, i_short_gnd_neg, i_short_vs} = 16'h0000;
        {i_short_load, i_open_load, i_offset_high, i_current_peak} = 16'h0000;
        cyc(6);
        i_sys_rst = 1'b0;
        cyc(4);
        chk("reset", 4'h2, {2'h0, o_standby, o_test_pulse});
        s_turn_on();
        s_perm();
        s_glitch();
        s_windows();
        wrap_up();
    end
endmodule : tb_top
